//--- core/rsc_defines.svh
// offsets, field positions, reset values and timing counts of the run control
`ifndef RSC_DEFINES_SVH
`define RSC_DEFINES_SVH

// register byte offsets
`define RSC_OFF_CTRL      8'h00
`define RSC_OFF_OFF_TIME_THRESHOLD      8'h04
`define RSC_OFF_TSHORT    8'h08
`define RSC_OFF_TLONG     8'h0c
`define RSC_OFF_SHUTOFF   8'h10
`define RSC_OFF_MINFREQ   8'h14
`define RSC_OFF_STATUS    8'h18
`define RSC_OFF_IRQ_STAT  8'h1c
`define RSC_OFF_IRQ_MASK  8'h20

// control word field positions
`define RSC_POS_SYSCFG    0
`define RSC_POS_RUN1      4
`define RSC_POS_RUN2      8
`define RSC_POS_ANALOG    12
`define RSC_POS_CONTRAST  16

// reset values, upper limits and the contrast floor
`define RSC_RST_SYSCFG    3'h0
`define RSC_MAX_SYSCFG    3'h4
`define RSC_RST_RUN1      2'h1
`define RSC_MAX_RUN1      2'h2
`define RSC_RST_RUN2      2'h1
`define RSC_RST_ANALOG    2'h0
`define RSC_RST_CONTRAST  6'h28
`define RSC_MIN_CONTRAST  6'h1e
`define RSC_RST_OFF_TIME_THRESHOLD      10'h01e
`define RSC_RST_TSHORT    10'h00f
`define RSC_RST_TLONG     10'h03c
`define RSC_MAX_TIME      10'h3e8
`define RSC_RST_SHUTOFF   9'h00c
`define RSC_MAX_SHUTOFF   9'h12c
`define RSC_RST_MINFREQ   9'h000

// one second of timekeeping
`define RSC_TICK_NS       1000000000
`define RSC_CLK_NS        4
`define RSC_TICK_CYCLES   (`RSC_TICK_NS / `RSC_CLK_NS)

`endif

//--- core/rsc_pkg.sv
// types shared by the run control block
package rsc_pkg;

  typedef enum logic [2:0] {
    RSC_SYS_RUNSTOP = 3'h0,
    RSC_SYS_CP      = 3'h1,
    RSC_SYS_POT     = 3'h2,
    RSC_SYS_LOOP    = 3'h3,
    RSC_SYS_CP_HOA  = 3'h4
  } rsc_sys_e;

  typedef enum logic [1:0] {
    RSC_M_STOP = 2'b00,
    RSC_M_RUN  = 2'b01,
    RSC_M_HOLD = 2'b10
  } rsc_motor_e;

  typedef struct packed {
    logic [2:0] sys_config;
    logic [1:0] run1_sel;
    logic [1:0] run2_sel;
    logic [1:0] analog_sel;
    logic [5:0] contrast;
  } rsc_ctrl_s;

  typedef struct packed {
    logic [9:0] off_time_threshold;
    logic [9:0] short_min_on_time;
    logic [9:0] long_min_on_time;
    logic [8:0] shutoff_offset;
    logic [8:0] lowest_motor_frequency;
  } rsc_cp_s;

  // irq bits: fault, start, stop, sleep
  typedef struct packed {
    logic sleep;
    logic stop;
    logic start;
    logic fault;
  } rsc_evt_s;

endpackage

//--- core/rsc_sync.sv
// three-stage pin synchroniser that passes a change once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module rsc_sync #(
  parameter int               WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT  = '0
) (
  input  wire logic             clock,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] pin,
  output logic      [WIDTH-1:0] level
);
  logic [WIDTH-1:0] s1;
  logic [WIDTH-1:0] s2;
  logic [WIDTH-1:0] s3;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s1 <= INIT;
      s2 <= INIT;
      s3 <= INIT;
    end else begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // per bit: only a level seen on two stages in a row is trusted
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      level <= INIT;
    end else begin
      level <= (s2 & s3) | (level & (s2 | s3));
    end
  end
endmodule
`default_nettype wire

//--- core/rsc_top.sv
// run input decode, analog select, short cycle guard and sleep, AXI4-Lite
//
// The implementer's own choices: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "rsc_defines.svh"

module rsc_top #(
  parameter int TICK_CYCLES = `RSC_TICK_CYCLES
) (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        run_input_first,
  input  wire logic        run_input_second,
  input  wire logic        enter_key,
  input  wire logic        loop_ok_first,
  input  wire logic        loop_ok_second,
  input  wire logic        at_setpoint,
  input  wire logic [8:0]  motor_freq,
  output logic             motor_run,
  output logic             motor_reverse,
  output logic             run_fault,
  output logic             analog_use_second,
  output logic             analog_fault,
  output logic             sleep,
  output logic             cp_params_visible,
  output logic [5:0]       contrast,
  output logic             irq
);

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  logic [4:0] pins_sync;
  logic       first_closed;
  logic       second_closed;
  logic       enter_lvl;
  logic       ok_first;
  logic       ok_second;
  logic       enter_prev;

  rsc_sync #(.WIDTH(5), .INIT(5'h00)) u_sync (
    .clock (clock),
    .rst_n (rst_n),
    .pin   ({loop_ok_second, loop_ok_first, enter_key,
             run_input_second, run_input_first}),
    .level (pins_sync)
  );

  assign first_closed  = pins_sync[0];
  assign second_closed = pins_sync[1];
  assign enter_lvl     = pins_sync[2];
  assign ok_first      = pins_sync[3];
  assign ok_second     = pins_sync[4];

  // ------------------------------------------------------------
  // settings
  // ------------------------------------------------------------
  rsc_pkg::rsc_ctrl_s ctrl;
  rsc_pkg::rsc_cp_s   cp;
  rsc_pkg::rsc_evt_s  irq_stat;
  rsc_pkg::rsc_evt_s  irq_mask;
  rsc_pkg::rsc_evt_s  evt;
  rsc_pkg::rsc_motor_e mstate;
  logic               cp_mode;

  // cp mode decode
  // configs 1 and 4
  assign cp_mode = (ctrl.sys_config == rsc_pkg::RSC_SYS_CP) ||
                   (ctrl.sys_config == rsc_pkg::RSC_SYS_CP_HOA);
  assign cp_params_visible = cp_mode;
  assign contrast = ctrl.contrast;

  // ------------------------------------------------------------
  // AXI4-Lite slave
  // ------------------------------------------------------------
  logic        aw_held;
  logic        w_held;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        do_write;
  logic        wr_hit;
  logic [31:0] wr_old;
  logic [31:0] wr_val;
  logic [31:0] rd_val;
  logic        rd_hit;

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign do_write      = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 8'h00;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (do_write) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (do_write) begin
        w_held <= 1'b0;
      end
    end
  end

  // register read view; pressure settings except lowest motor frequency hidden outside cp modes
  function automatic logic [31:0] reg_view(input logic [7:0] a);
    logic [31:0] v;
    v = 32'h0000_0000;
    unique case (a)
      `RSC_OFF_CTRL: begin
        v[`RSC_POS_SYSCFG +: 3]   = ctrl.sys_config;
        v[`RSC_POS_RUN1 +: 2]     = ctrl.run1_sel;
        v[`RSC_POS_RUN2 +: 2]     = ctrl.run2_sel;
        v[`RSC_POS_ANALOG +: 2]   = ctrl.analog_sel;
        v[`RSC_POS_CONTRAST +: 6] = ctrl.contrast;
      end
      `RSC_OFF_OFF_TIME_THRESHOLD:     v[9:0] = cp_mode ? cp.off_time_threshold : 10'h000;
      `RSC_OFF_TSHORT:   v[9:0] = cp_mode ? cp.short_min_on_time : 10'h000;
      `RSC_OFF_TLONG:    v[9:0] = cp_mode ? cp.long_min_on_time : 10'h000;
      `RSC_OFF_SHUTOFF:  v[8:0] = cp_mode ? cp.shutoff_offset : 9'h000;
      `RSC_OFF_MINFREQ:  v[8:0] = cp.lowest_motor_frequency;
      `RSC_OFF_STATUS:   v[7:0] = {cp_mode, sleep, analog_fault,
                                   analog_use_second, run_fault,
                                   motor_reverse, mstate};
      `RSC_OFF_IRQ_STAT: v[3:0] = irq_stat;
      `RSC_OFF_IRQ_MASK: v[3:0] = irq_mask;
      default:           v = 32'h0000_0000;
    endcase
    return v;
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    return (a[1:0] == 2'b00) && (a <= `RSC_OFF_IRQ_MASK);
  endfunction

  assign wr_hit = mapped(aw_addr);
  assign rd_hit = mapped(s_axi_araddr);
  // a function in a continuous assign would not see register changes
  always_comb begin
    wr_old = reg_view(aw_addr);
    rd_val = reg_view(s_axi_araddr);
  end

  // byte lanes merge the new data into the current view
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      wr_val[i*8 +: 8] = w_strb[i] ? w_data[i*8 +: 8] : wr_old[i*8 +: 8];
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'b00;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? 2'b00 : 2'b10;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_val;
      s_axi_rresp  <= rd_hit ? 2'b00 : 2'b10;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // setting registers, clamped to their ranges on write
  // ------------------------------------------------------------
  function automatic logic [9:0] clamp_time(input logic [9:0] t);
    return (t > `RSC_MAX_TIME) ? `RSC_MAX_TIME : t;
  endfunction

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctrl.sys_config <= `RSC_RST_SYSCFG;
      ctrl.run1_sel   <= `RSC_RST_RUN1;
      ctrl.run2_sel   <= `RSC_RST_RUN2;
      ctrl.analog_sel <= `RSC_RST_ANALOG;
      ctrl.contrast   <= `RSC_RST_CONTRAST;
    end else if (do_write && aw_addr == `RSC_OFF_CTRL) begin
      ctrl.sys_config <= (wr_val[`RSC_POS_SYSCFG +: 3] > `RSC_MAX_SYSCFG) ?
                         `RSC_MAX_SYSCFG : wr_val[`RSC_POS_SYSCFG +: 3];
      // first input limit
      // codes 0 to 2
      ctrl.run1_sel   <= (wr_val[`RSC_POS_RUN1 +: 2] > `RSC_MAX_RUN1) ?
                         `RSC_MAX_RUN1 : wr_val[`RSC_POS_RUN1 +: 2];
      // second input takes all four
      // codes 0 to 3
      ctrl.run2_sel   <= wr_val[`RSC_POS_RUN2 +: 2];
      ctrl.analog_sel <= wr_val[`RSC_POS_ANALOG +: 2];
      // contrast floor
      // held at 30 or above
      ctrl.contrast   <= (wr_val[`RSC_POS_CONTRAST +: 6] < `RSC_MIN_CONTRAST) ?
                         `RSC_MIN_CONTRAST : wr_val[`RSC_POS_CONTRAST +: 6];
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cp.off_time_threshold     <= `RSC_RST_OFF_TIME_THRESHOLD;
      cp.short_min_on_time      <= `RSC_RST_TSHORT;
      cp.long_min_on_time       <= `RSC_RST_TLONG;
      cp.shutoff_offset         <= `RSC_RST_SHUTOFF;
      cp.lowest_motor_frequency <= `RSC_RST_MINFREQ;
    end else if (do_write) begin
      // pressure group except lowest motor frequency locked
      // outside cp modes
      if (cp_mode) begin
        unique case (aw_addr)
          `RSC_OFF_OFF_TIME_THRESHOLD:   cp.off_time_threshold <= clamp_time(wr_val[9:0]);
          `RSC_OFF_TSHORT: cp.short_min_on_time  <= clamp_time(wr_val[9:0]);
          `RSC_OFF_TLONG:  cp.long_min_on_time   <= clamp_time(wr_val[9:0]);
          `RSC_OFF_SHUTOFF:
            cp.shutoff_offset <= (wr_val[8:0] > `RSC_MAX_SHUTOFF) ?
                                 `RSC_MAX_SHUTOFF : wr_val[8:0];
          default: ;
        endcase
      end
      if (aw_addr == `RSC_OFF_MINFREQ) begin
        cp.lowest_motor_frequency <= wr_val[8:0];
      end
    end
  end

  // ------------------------------------------------------------
  // run inputs and latched fault
  // ------------------------------------------------------------
  logic perm_first;
  logic perm_second;
  logic enter_press;

  // first input polarity
  // closed, open or always
  always_comb begin
    unique case (ctrl.run1_sel)
      2'h0:    perm_first = first_closed;
      2'h1:    perm_first = !first_closed;
      default: perm_first = 1'b1;
    endcase
  end

  // second input polarity; latch and reverse codes do not gate run here
  // same meaning as first
  always_comb begin
    unique case (ctrl.run2_sel)
      2'h0:    perm_second = second_closed;
      2'h1:    perm_second = !second_closed;
      default: perm_second = 1'b1;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      enter_prev <= 1'b0;
    end else begin
      enter_prev <= enter_lvl;
    end
  end
  assign enter_press = enter_lvl && !enter_prev;

  // open contact latches, enter releases; a still-open contact wins
  // open stops and flags
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      run_fault <= 1'b0;
    end else if (ctrl.run2_sel == 2'h2 && !second_closed) begin
      run_fault <= 1'b1;
    end else if (enter_press) begin
      run_fault <= 1'b0;
    end
  end

  // direction follows the open contact
  // open reverses
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      motor_reverse <= 1'b0;
    end else begin
      motor_reverse <= (ctrl.run2_sel == 2'h3) && !second_closed;
    end
  end

  // ------------------------------------------------------------
  // analog input select
  // ------------------------------------------------------------
  // primary with optional backup
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      analog_use_second <= 1'b0;
      analog_fault      <= 1'b0;
    end else begin
      unique case (ctrl.analog_sel)
        2'h0: begin
          analog_use_second <= 1'b0;
          analog_fault      <= !ok_first;
        end
        2'h1: begin
          analog_use_second <= 1'b1;
          analog_fault      <= !ok_second;
        end
        2'h2: begin
          analog_use_second <= !ok_first && ok_second;
          analog_fault      <= !ok_first && !ok_second;
        end
        default: begin
          analog_use_second <= !(ok_first && !ok_second);
          analog_fault      <= !ok_first && !ok_second;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // sleep decision
  // ------------------------------------------------------------
  logic [9:0] sleep_freq;
  assign sleep_freq = {1'b0, cp.lowest_motor_frequency} +
                      {1'b0, cp.shutoff_offset};

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sleep <= 1'b0;
    end else begin
      sleep <= cp_mode && at_setpoint && ({1'b0, motor_freq} <= sleep_freq);
    end
  end

  // ------------------------------------------------------------
  // short cycle guard
  // ------------------------------------------------------------
  logic        tick;
  logic [31:0] tick_cnt;
  logic [9:0]  sec_cnt;
  logic [9:0]  min_on;
  logic        run_req;
  logic        in_on;
  logic        starting;
  logic        stopping;
  rsc_pkg::rsc_motor_e next_mstate;

  // a fault stops at once; the minimum on-time protects only sleep/stop
  assign run_req  = perm_first && perm_second && !run_fault && !sleep;
  assign in_on    = (mstate != rsc_pkg::RSC_M_STOP);
  assign tick     = (tick_cnt == 32'(TICK_CYCLES - 1));
  assign starting = (mstate == rsc_pkg::RSC_M_STOP) && run_req && !run_fault;
  assign stopping = (next_mstate == rsc_pkg::RSC_M_STOP) && in_on;

  always_comb begin
    next_mstate = mstate;
    unique case (mstate)
      rsc_pkg::RSC_M_STOP: if (starting) next_mstate = rsc_pkg::RSC_M_RUN;
      rsc_pkg::RSC_M_RUN:  if (run_fault) next_mstate = rsc_pkg::RSC_M_STOP;
                           else if (!run_req) next_mstate = rsc_pkg::RSC_M_HOLD;
      default: begin
        if (run_fault || sec_cnt >= min_on) next_mstate = rsc_pkg::RSC_M_STOP;
        else if (run_req) next_mstate = rsc_pkg::RSC_M_RUN;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mstate <= rsc_pkg::RSC_M_STOP;
    end else begin
      mstate <= next_mstate;
    end
  end
  assign motor_run = in_on;

  // the second count restarts on each start and stop, so both periods
  // are whole seconds; it saturates above the largest setting
  // seconds since the last start or stop
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt <= 32'h0000_0000;
      sec_cnt  <= 10'h3ff;
    end else if (starting || stopping) begin
      tick_cnt <= 32'h0000_0000;
      sec_cnt  <= 10'h000;
    end else if (tick) begin
      tick_cnt <= 32'h0000_0000;
      if (sec_cnt != 10'h3ff) sec_cnt <= sec_cnt + 10'h001;
    end else begin
      tick_cnt <= tick_cnt + 32'h0000_0001;
    end
  end

  // judged against the off time at start
  // long rest gives short minimum
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      min_on <= 10'h000;
    end else if (starting) begin
      min_on <= (cp_mode && sec_cnt > cp.off_time_threshold) ?
                cp.short_min_on_time :
                (cp_mode ? cp.long_min_on_time : 10'h000);
    end
  end

  // ------------------------------------------------------------
  // interrupts
  // ------------------------------------------------------------
  logic fault_prev;
  logic sleep_prev;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      fault_prev <= 1'b0;
      sleep_prev <= 1'b0;
    end else begin
      fault_prev <= run_fault;
      sleep_prev <= sleep;
    end
  end

  assign evt = '{sleep: sleep && !sleep_prev, stop: stopping,
                 start: starting, fault: run_fault && !fault_prev};

  // a new event outranks a same-cycle clear
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat <= '0;
      irq_mask <= '0;
    end else begin
      if (do_write && aw_addr == `RSC_OFF_IRQ_STAT) begin
        irq_stat <= (irq_stat & ~rsc_pkg::rsc_evt_s'(wr_val[3:0])) | evt;
      end else begin
        irq_stat <= irq_stat | evt;
      end
      if (do_write && aw_addr == `RSC_OFF_IRQ_MASK) begin
        irq_mask <= rsc_pkg::rsc_evt_s'(wr_val[3:0]);
      end
    end
  end

  assign irq = |(irq_stat & irq_mask);

endmodule
`default_nettype wire

//--- tb/rsc_props.sv
// assertions on the run control ports
`timescale 1ns/1ps
`default_nettype none
module rsc_props (
  input wire logic       clock,
  input wire logic       rst_n,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_bready,
  input wire logic       s_axi_arvalid,
  input wire logic       s_axi_arready,
  input wire logic       s_axi_rvalid,
  input wire logic       s_axi_rready,
  input wire logic       enter_key,
  input wire logic       at_setpoint,
  input wire logic       motor_run,
  input wire logic       run_fault,
  input wire logic       sleep,
  input wire logic       cp_params_visible,
  input wire logic [5:0] contrast
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  chk_contrast_floor: assert property (contrast >= 6'h1e)
    else $error("contrast low");
  chk_fault_stops: assert property (run_fault [*2] |-> !motor_run)
    else $error("run in fault");
  // enter is filtered, so eight quiet cycles rule out a clear
  chk_fault_latch: assert property (
    (!enter_key) [*8] ##0 run_fault |=> run_fault)
    else $error("fault lost");
  chk_sleep_cause: assert property (
    sleep |-> $past(at_setpoint && cp_params_visible))
    else $error("bad sleep");
  chk_write_ack: assert property (
    $fell(s_axi_bvalid) |-> $past(s_axi_bready))
    else $error("write answer dropped");
  chk_read_ack: assert property (
    $fell(s_axi_rvalid) |-> $past(s_axi_rready))
    else $error("read answer dropped");
  chk_read_late: assert property (
    s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
    else $error("read answer late");
  chk_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");
endmodule
bind rsc_top rsc_props i_props (.*);
`default_nettype wire

//--- tb/rsc_far.sv
// far side model: run contacts, enter key and loop health
`timescale 1ns/1ps
`default_nettype none
module rsc_far (
  input  wire logic clock,
  output logic      run_input_first = 1'b0,
  output logic      run_input_second = 1'b1,
  output logic      enter_key = 1'b0,
  output logic      loop_ok_first = 1'b1,
  output logic      loop_ok_second = 1'b1
);
  // contacts move on an edge, after the design has sampled the old level
  task automatic set(input logic c1, c2, ok1, ok2);
    @(posedge clock);
    run_input_first <= c1;
    run_input_second <= c2;
    loop_ok_first <= ok1;
    loop_ok_second <= ok2;
  endtask
  // a press outlasts the pin filter so its edge is seen
  task automatic press();
    @(posedge clock);
    enter_key <= 1'b1;
    repeat (8) @(posedge clock);
    enter_key <= 1'b0;
  endtask
endmodule
`default_nettype wire

//--- tb/rsc_top_tb.sv
// self-checking bench for the run control block
`timescale 1ns/1ps
`default_nettype none
module rsc_top_tb;
  // ten cycles stand for a second so on-times fit a short run
  localparam int TICK = 10;
  // select, second ok, first ok, second expected
  localparam logic [4:0] AN [6] = '{5'h06, 5'h0f, 5'h15, 5'h16, 5'h1f, 5'h1a};
  logic        clock = 1'b0, rst_n = 1'b0, at_setpoint = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, q;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [8:0]  motor_freq = 9'h000;
  logic [1:0]  rsp;
  int          fails = 0, num_checks = 0, cnt;
  wire logic   s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire logic   s_axi_rvalid, motor_run, motor_reverse, run_fault, irq, sleep;
  wire logic   analog_use_second, analog_fault, cp_params_visible;
  wire logic   run_input_first, run_input_second, enter_key;
  wire logic   loop_ok_first, loop_ok_second;
  wire logic [1:0]  s_axi_bresp, s_axi_rresp;
  wire logic [31:0] s_axi_rdata;
  wire logic [5:0]  contrast;
  rsc_top #(.TICK_CYCLES(TICK)) i_dut (.*);
  rsc_far i_far (.*);
  always #2 clock = ~clock;
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic guard(input int n);
    if (n > 200) begin
      fails++;
      wrap_up();
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(negedge clock);
  endtask
  // ready is judged mid-cycle, so the release lands on the taking edge
  task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tr, fin;
    int n;
    n = 0;
    fin = 1'b0;
    @(posedge clock);
    if (we) begin
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
    end else begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
    end
    while (!fin) begin
      @(negedge clock);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tr = s_axi_arvalid && s_axi_arready;
      fin = we ? s_axi_bvalid : s_axi_rvalid;
      q = s_axi_rdata;
      rsp = we ? s_axi_bresp : s_axi_rresp;
      @(posedge clock);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tr) s_axi_arvalid <= 1'b0;
      if (fin) {s_axi_bready, s_axi_rready} <= 2'b00;
      n++;
      guard(n);
    end
    wt(2);
  endtask
  task automatic wrun(input logic e);
    cnt = 0;
    while (motor_run !== e) begin
      @(negedge clock);
      cnt++;
      guard(cnt);
    end
  endtask
  task automatic s_reset();
    bus(1'b0, 8'h00, 32'h0);
    chk("ctrl", q, 32'h0028_0110);
    chk("contrast", 32'(contrast), 32'h28);
    bus(1'b1, 8'h00, 32'h0000_0130);
    chk("okay", 32'(rsp), 32'h0);
    bus(1'b0, 8'h00, 32'h0);
    chk("clamp", q, 32'h001e_0120);
    bus(1'b0, 8'h24, 32'h0);
    chk("unmapped", 32'(rsp), 32'h2);
    bus(1'b1, 8'h24, 32'h0);
    chk("wunmapped", 32'(rsp), 32'h2);
    bus(1'b1, 8'h04, 32'h5);
    bus(1'b0, 8'h04, 32'h0);
    chk("hidden", q, 32'h0);
  endtask
  task automatic s_pol();
    logic [1:0] k;
    for (int i = 0; i < 10; i++) begin
      k = (i < 6) ? 2'(i / 2) : 2'((i - 6) / 2);
      if (i < 6) bus(1'b1, 8'h00, {26'h0, k, 4'h0});
      else bus(1'b1, 8'h00, {22'h0, k, 8'h20});
      if (i < 6) i_far.set(i[0], 1'b1, 1'b1, 1'b1);
      else i_far.set(1'b1, i[0], 1'b1, 1'b1);
      wt(10);
      chk("run", 32'(motor_run), 32'(k[1] | (i[0] ^ k[0])));
    end
  endtask
  task automatic s_run_input_second();
    bus(1'b1, 8'h20, 32'h1);
    bus(1'b1, 8'h00, 32'h0000_0220);
    i_far.set(1'b1, 1'b0, 1'b1, 1'b1);
    wt(10);
    chk("fault", 32'(run_fault), 32'h1);
    chk("stop", 32'(motor_run), 32'h0);
    chk("irq", 32'(irq), 32'h1);
    bus(1'b1, 8'h20, 32'h0);
    chk("masked", 32'(irq), 32'h0);
    i_far.set(1'b1, 1'b1, 1'b1, 1'b1);
    wt(20);
    chk("latched", 32'(motor_run), 32'h0);
    i_far.press();
    wt(10);
    chk("cleared", 32'(run_fault), 32'h0);
    chk("rerun", 32'(motor_run), 32'h1);
    bus(1'b1, 8'h20, 32'h1);
    chk("unmasked", 32'(irq), 32'h1);
    bus(1'b1, 8'h1c, 32'hf);
    chk("w1c", 32'(irq), 32'h0);
    bus(1'b1, 8'h00, 32'h0000_0320);
    i_far.set(1'b1, 1'b0, 1'b1, 1'b1);
    wt(10);
    chk("reverse", 32'(motor_reverse), 32'h1);
    i_far.set(1'b1, 1'b1, 1'b1, 1'b1);
    wt(10);
    chk("forward", 32'(motor_reverse), 32'h0);
  endtask
  task automatic s_analog();
    for (int i = 0; i < 6; i++) begin
      bus(1'b1, 8'h00, {18'h0, AN[i][4:3], 12'h220});
      i_far.set(1'b1, 1'b1, AN[i][1], AN[i][2]);
      wt(10);
      chk("loop", 32'(analog_use_second), 32'(AN[i][0]));
      chk("feed", 32'(analog_fault), 32'h0);
    end
    i_far.set(1'b1, 1'b1, 1'b0, 1'b0);
    wt(10);
    chk("nofeed", 32'(analog_fault), 32'h1);
  endtask
  task automatic s_cp();
    i_far.set(1'b0, 1'b1, 1'b1, 1'b1);
    bus(1'b1, 8'h00, 32'h0000_0001);
    chk("cp", 32'(cp_params_visible), 32'h1);
    bus(1'b0, 8'h04, 32'h0);
    chk("locked", q, 32'h1e);
    bus(1'b1, 8'h04, 32'h2);
    bus(1'b1, 8'h08, 32'h3);
    bus(1'b1, 8'h0c, 32'h6);
    bus(1'b0, 8'h10, 32'h0);
    chk("offset", q, 32'hc);
    for (int i = 0; i < 2; i++) begin
      wt(40 - 40 * i);
      i_far.set(1'b1, 1'b1, 1'b1, 1'b1);
      wrun(1'b1);
      i_far.set(1'b0, 1'b1, 1'b1, 1'b1);
      wrun(1'b0);
      chk("on", 32'(cnt > 15 + 30 * i && cnt < 45 + 30 * i), 32'h1);
    end
    bus(1'b1, 8'h14, 32'h14);
    @(posedge clock);
    motor_freq <= 9'h020;
    at_setpoint <= 1'b1;
    wt(4);
    chk("sleep", 32'(sleep), 32'h1);
    @(posedge clock);
    motor_freq <= 9'h021;
    wt(4);
    chk("awake", 32'(sleep), 32'h0);
    bus(1'b1, 8'h00, 32'h0000_0007);
    chk("hoa", 32'(cp_params_visible), 32'h1);
  endtask
  initial begin
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    s_reset();
    s_pol();
    s_run_input_second();
    s_analog();
    s_cp();
    wrap_up();
  end
endmodule
`default_nettype wire
